// ---- common/ect_defines.svh ----
// constants of the expansion command timing block
`ifndef ECT_DEFINES_SVH
`define ECT_DEFINES_SVH

// i/o port addresses
`define ECT_ADDR_W        10
`define ECT_PTR_ADDR      10'h072
`define ECT_DATA_ADDR     10'h073

// pointer byte bits that form the index
`define ECT_IDX_B3        7
`define ECT_IDX_B2        6
`define ECT_IDX_B1        3
`define ECT_IDX_B0        2

// register indices
`define ECT_IDX_BALE_DLY  4'h0
`define ECT_IDX_BALE_WID  4'h1
`define ECT_IDX_NAR_DLY   4'h3
`define ECT_IDX_NAR_WS    4'h4
`define ECT_IDX_WIO_WS    4'h5
`define ECT_IDX_WMEM_DLY  4'h6
`define ECT_IDX_WMEM_WS   4'h7
`define ECT_IDX_ZW_MIN    4'h8
`define ECT_IDX_LRD_WS    4'h9
`define ECT_IDX_LWR_WS    4'hA
`define ECT_IDX_LIO_DLY   4'hC
// spare indices inside the table, writes there are dropped
`define ECT_IDX_SPARE_LO  4'h2
`define ECT_IDX_SPARE_HI  4'hB

// reset values
`define ECT_RST_BALE_DLY  2'h0
`define ECT_RST_BALE_WID  2'h1
`define ECT_RST_NAR_DLY   4'h1
`define ECT_RST_NAR_WS    4'h4
`define ECT_RST_WIO_WS    4'h1
`define ECT_RST_WMEM_DLY  4'h0
`define ECT_RST_WMEM_WS   4'h1
`define ECT_RST_ZW_MIN    4'h0
`define ECT_RST_LRD_WS    4'h1
`define ECT_RST_LWR_WS    4'h1
`define ECT_RST_LIO_DLY   4'h1

// counting
`define ECT_CNT_W         5
`define ECT_PHASE_LAST    1'b1

`endif

// ---- common/ect_pkg.sv ----
// types of the expansion command timing block
`include "ect_defines.svh"
package ect_pkg;

  typedef struct packed {
    logic [1:0] latch_strobe_delay;
    logic [1:0] latch_strobe_width;
    logic [3:0] narrow_cycle_cmd_delay;
    logic [3:0] narrow_cycle_waits;
    logic [3:0] wide_io_waits;
    logic [3:0] wide_mem_cmd_delay;
    logic [3:0] wide_mem_waits;
    logic [3:0] zero_wait_minimum;
    logic [3:0] local_read_waits;
    logic [3:0] local_write_waits;
    logic [3:0] local_io_cmd_delay;
  } ect_timing_t;

  // pin levels, all active high as seen by this block
  typedef struct packed {
    logic cpu_ale;
    logic is_memory;
    logic is_write;
    logic local_board_select;
    logic memcs16;
    logic iocs16;
    logic zero_wait_request;
    logic iochrdy;
    logic high_speed;
  } ect_pins_t;

  typedef struct packed {
    logic bale;
    logic bus_memory_read_cmd_n;
    logic bus_memory_write_cmd_n;
    logic bus_io_read_cmd_n;
    logic bus_io_write_cmd_n;
  } ect_cmd_t;

  typedef struct packed {
    logic                  wr;
    logic [`ECT_ADDR_W-1:0] addr;
    logic [7:0]            data;
  } ect_io_wr_t;

  typedef enum logic [1:0] {BALE_IDLE, BALE_DELAY, BALE_HIGH} ect_bale_st_t;
  typedef enum logic [1:0] {CMD_IDLE, CMD_DELAY, CMD_WAIT} ect_cmd_st_t;

  typedef struct packed {
    logic is_memory;
    logic is_write;
  } ect_kind_t;

endpackage

// ---- rtl/ect_cycle_ctrl.sv ----
// expansion bus command timing: strobe, command delay and wait states
`timescale 1ns/100ps
`default_nettype none
`include "ect_defines.svh"
module ect_cycle_ctrl (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               reset,
  // cpu i/o port access
  input  wire ect_pkg::ect_io_wr_t io_wr,
  input  wire logic               io_rd,
  input  wire logic [`ECT_ADDR_W-1:0] io_rd_addr,
  output logic      [7:0]         io_rdata,
  output logic                    io_rdata_oe,
  // cycle pins, asynchronous
  input  wire ect_pkg::ect_pins_t cycle_pins,
  // bus side
  output ect_pkg::ect_cmd_t       bus_cmd,
  output logic                    cpu_ready
);
  import ect_pkg::*;

  typedef struct packed {
    ect_pins_t            sync1;
    ect_pins_t            sync2;
    logic                 ale_prev;
    ect_bale_st_t         bale_st;
    ect_cmd_st_t          cmd_st;
    ect_kind_t            kind;
    logic [`ECT_CNT_W-1:0] waits;
    logic                 phase;
    logic [`ECT_CNT_W-1:0] elapsed;
    ect_cmd_t             cmd;
    logic                 ready;
  } ect_main_state_t;

  localparam ect_cmd_t CMD_IDLE_VAL = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};

  ect_main_state_t cur_ff;
  ect_main_state_t nxt_st;
  ect_timing_t     timing;

  ////////////////////////////////////////////////////////////////////////
  // register file

  ect_timing_regs u_regs (
    .clk    (clk),
    .reset  (reset),
    .io_wr  (io_wr),
    .timing (timing)
  );

  // never answers a read, whatever the address
  assign io_rdata    = 8'h00;
  assign io_rdata_oe = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // counters

  logic                  b_load;
  logic [`ECT_CNT_W-1:0] b_val;
  logic                  b_dec;
  logic [`ECT_CNT_W-1:0] b_cnt;
  logic                  b_zero;
  logic                  d_load;
  logic [`ECT_CNT_W-1:0] d_val;
  logic                  d_dec;
  logic                  d_zero;
  logic                  w_load;
  logic                  w_dec;
  logic [`ECT_CNT_W-1:0] w_cnt;
  logic                  w_zero;

  ect_down_counter #(.W(`ECT_CNT_W)) u_bale_cnt (
    .clk      (clk),
    .reset    (reset),
    .load     (b_load),
    .load_val (b_val),
    .dec      (b_dec),
    .count    (b_cnt),
    .is_zero  (b_zero)
  );

  ect_down_counter #(.W(`ECT_CNT_W)) u_delay_cnt (
    .clk      (clk),
    .reset    (reset),
    .load     (d_load),
    .load_val (d_val),
    .dec      (d_dec),
    .count    (),
    .is_zero  (d_zero)
  );

  ect_down_counter #(.W(`ECT_CNT_W)) u_wait_cnt (
    .clk      (clk),
    .reset    (reset),
    .load     (w_load),
    .load_val (cur_ff.waits),
    .dec      (w_dec),
    .count    (w_cnt),
    .is_zero  (w_zero)
  );

  ////////////////////////////////////////////////////////////////////////
  // cycle classification

  ect_pins_t  pin;
  logic       ale_rise;
  logic       ale_fall;
  logic [3:0] sel_delay;
  logic [3:0] sel_waits;
  logic       zw_ok;
  logic       wait_done;

  assign pin      = cur_ff.sync2;
  assign ale_rise = pin.cpu_ale && !cur_ff.ale_prev;
  assign ale_fall = !pin.cpu_ale && cur_ff.ale_prev;
  assign zw_ok    = pin.zero_wait_request && (cur_ff.elapsed >= {1'b0, timing.zero_wait_minimum});
  // the ready pin lengthens a cycle once its count has run out, unless an accepted zero-wait request ends it
  assign wait_done = w_zero && pin.iochrdy;

  always_comb begin
    sel_delay = timing.narrow_cycle_cmd_delay;
    sel_waits = timing.narrow_cycle_waits;
    if (pin.local_board_select) begin
      if (pin.is_memory) begin
        sel_delay = 4'h0;
      end else begin
        sel_delay = timing.local_io_cmd_delay;
      end
      // local i/o shares the local memory wait counts
      sel_waits = pin.is_write ? timing.local_write_waits : timing.local_read_waits;
    end else if (pin.is_memory && pin.memcs16) begin
      sel_delay = timing.wide_mem_cmd_delay;
      sel_waits = timing.wide_mem_waits;
    end else if (!pin.is_memory && pin.iocs16) begin
      sel_waits = timing.wide_io_waits;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    nxt_st          = cur_ff;
    nxt_st.sync1    = cycle_pins;
    nxt_st.sync2    = cur_ff.sync1;
    nxt_st.ale_prev = pin.cpu_ale;
    nxt_st.ready    = 1'b0;
    b_load = 1'b0;
    b_val  = '0;
    b_dec  = 1'b0;
    d_load = 1'b0;
    d_val  = '0;
    d_dec  = 1'b0;
    w_load = 1'b0;
    w_dec  = 1'b0;

    // latch strobe
    unique case (cur_ff.bale_st)
      BALE_IDLE: ;
      BALE_DELAY: begin
        if (b_zero) begin
          nxt_st.bale_st = BALE_HIGH;
          nxt_st.cmd.bale = 1'b1;
          b_load = 1'b1;
          b_val  = {3'b000, timing.latch_strobe_width};
        end else begin
          b_dec = 1'b1;
        end
      end
      BALE_HIGH: begin
        if (b_cnt <= `ECT_CNT_W'(1)) begin
          nxt_st.bale_st = BALE_IDLE;
          nxt_st.cmd.bale = 1'b0;
        end else begin
          b_dec = 1'b1;
        end
      end
    endcase
    if (ale_rise) begin
      nxt_st.bale_st = BALE_DELAY;
      nxt_st.cmd.bale = 1'b0;
      b_load = 1'b1;
      b_val  = {3'b000, timing.latch_strobe_delay};
    end

    // command and wait states
    unique case (cur_ff.cmd_st)
      CMD_IDLE: begin
        if (ale_fall) begin
          nxt_st.cmd_st = CMD_DELAY;
          nxt_st.kind   = '{pin.is_memory, pin.is_write};
          // extra synchronising wait at the fast clock
          nxt_st.waits  = {1'b0, sel_waits} + {4'b0000, pin.high_speed};
          d_load = 1'b1;
          d_val  = {1'b0, sel_delay};
        end
      end
      CMD_DELAY: begin
        if (d_zero) begin
          nxt_st.cmd_st  = CMD_WAIT;
          nxt_st.phase   = 1'b0;
          nxt_st.elapsed = '0;
          w_load = 1'b1;
          nxt_st.cmd.bus_memory_read_cmd_n  = !(cur_ff.kind.is_memory && !cur_ff.kind.is_write);
          nxt_st.cmd.bus_memory_write_cmd_n = !(cur_ff.kind.is_memory && cur_ff.kind.is_write);
          nxt_st.cmd.bus_io_read_cmd_n      = !(!cur_ff.kind.is_memory && !cur_ff.kind.is_write);
          nxt_st.cmd.bus_io_write_cmd_n     = !(!cur_ff.kind.is_memory && cur_ff.kind.is_write);
        end else begin
          d_dec = 1'b1;
        end
      end
      CMD_WAIT: begin
        if (wait_done || zw_ok) begin
          nxt_st.cmd_st = CMD_IDLE;
          nxt_st.ready  = 1'b1;
          nxt_st.cmd.bus_memory_read_cmd_n  = 1'b1;
          nxt_st.cmd.bus_memory_write_cmd_n = 1'b1;
          nxt_st.cmd.bus_io_read_cmd_n      = 1'b1;
          nxt_st.cmd.bus_io_write_cmd_n     = 1'b1;
        end else begin
          nxt_st.phase = !cur_ff.phase;
          if ((cur_ff.phase == `ECT_PHASE_LAST) && !w_zero) begin
            w_dec = 1'b1;
            nxt_st.elapsed = cur_ff.elapsed + `ECT_CNT_W'(1);
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cur_ff         <= '0;
      cur_ff.bale_st <= BALE_IDLE;
      cur_ff.cmd_st  <= CMD_IDLE;
      cur_ff.cmd     <= CMD_IDLE_VAL;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  assign bus_cmd   = cur_ff.cmd;
  assign cpu_ready = cur_ff.ready;

  ////////////////////////////////////////////////////////////////////////
  // checks

  logic cmd_on;
  assign cmd_on = !(cur_ff.cmd.bus_memory_read_cmd_n && cur_ff.cmd.bus_memory_write_cmd_n &&
                    cur_ff.cmd.bus_io_read_cmd_n && cur_ff.cmd.bus_io_write_cmd_n);

  sequence s_fall_local_mem;
    ale_fall && pin.local_board_select && pin.is_memory;
  endsequence

  sequence s_cmd_starts;
    !cmd_on ##1 cmd_on;
  endsequence

  a_no_readback: assert property (@(posedge clk) disable iff (reset)
    io_rd |-> !io_rdata_oe)
    else $error("read data driven on a write-only port");

  a_bale_delay0: assert property (@(posedge clk) disable iff (reset)
    (ale_rise && timing.latch_strobe_delay == 2'h0) |-> !bus_cmd.bale ##2 bus_cmd.bale)
    else $error("strobe not started at delay zero");

  a_bale_delay3: assert property (@(posedge clk) disable iff (reset)
    (ale_rise && timing.latch_strobe_delay == 2'h3) |-> ##1 !bus_cmd.bale[*4] ##1 bus_cmd.bale)
    else $error("strobe not started after delay three");

  a_bale_width2: assert property (@(posedge clk) disable iff (reset)
    ($rose(bus_cmd.bale) && timing.latch_strobe_width == 2'h2 && !ale_rise && !$past(ale_rise))
    |-> bus_cmd.bale ##1 (bus_cmd.bale || ale_rise) ##1 (!bus_cmd.bale || $past(ale_rise)))
    else $error("strobe width two not kept");

  a_local_mem_nodly: assert property (@(posedge clk) disable iff (reset)
    (s_fall_local_mem and (cur_ff.cmd_st == CMD_IDLE)) |-> ##1 s_cmd_starts)
    else $error("local memory command was delayed");

  a_wait_two_clk: assert property (@(posedge clk) disable iff (reset)
    (cur_ff.cmd_st == CMD_WAIT && cur_ff.phase == 1'b0 && !w_zero && !zw_ok)
    |=> (w_cnt == $past(w_cnt)) ##1 (cur_ff.cmd_st != CMD_WAIT || zw_ok || w_cnt == $past(w_cnt, 2) - 5'h01))
    else $error("wait state not two clocks long");

  a_ready_hold: assert property (@(posedge clk) disable iff (reset)
    (cur_ff.cmd_st == CMD_WAIT && !pin.iochrdy && !zw_ok) |=> !cpu_ready && cmd_on)
    else $error("cycle ended while ready held low");

  a_zero_wait_min: assert property (@(posedge clk) disable iff (reset)
    (cpu_ready && !$past(w_zero)) |-> ($past(cur_ff.elapsed) >= {1'b0, $past(timing.zero_wait_minimum)}))
    else $error("zero-wait ended cycle before minimum");

  a_ready_pulse: assert property (@(posedge clk) disable iff (reset)
    $rose(cpu_ready) |-> $fell(cmd_on) ##1 !cpu_ready)
    else $error("ready not a single pulse at command end");
endmodule
`default_nettype wire

// ---- rtl/ect_down_counter.sv ----
// loadable down counter shared by strobe, delay and wait timing
`timescale 1ns/100ps
`default_nettype none
module ect_down_counter #(
  parameter int unsigned W = 5
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         dec,
  // state
  output logic      [W-1:0] count,
  output logic              is_zero
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } ect_cnt_state_t;

  ect_cnt_state_t cur_ff;
  ect_cnt_state_t nxt_cnt;

  always_comb begin
    nxt_cnt = cur_ff;
    if (load) begin
      nxt_cnt.cnt = load_val;
    end else if (dec && (cur_ff.cnt != '0)) begin
      nxt_cnt.cnt = cur_ff.cnt - W'(1);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cnt;
    end
  end

  assign count   = cur_ff.cnt;
  assign is_zero = (cur_ff.cnt == '0);
endmodule
`default_nettype wire

// ---- rtl/ect_timing_regs.sv ----
// indexed write-only timing register file
`timescale 1ns/100ps
`default_nettype none
`include "ect_defines.svh"
module ect_timing_regs (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               reset,
  // i/o write port
  input  wire ect_pkg::ect_io_wr_t io_wr,
  // settings
  output ect_pkg::ect_timing_t    timing
);
  import ect_pkg::*;

  typedef struct packed {
    logic [3:0]  ptr;
    ect_timing_t tm;
  } ect_reg_state_t;

  localparam ect_reg_state_t RESET_VAL = '{
    ptr: 4'h0,
    tm: '{`ECT_RST_BALE_DLY, `ECT_RST_BALE_WID, `ECT_RST_NAR_DLY, `ECT_RST_NAR_WS,
          `ECT_RST_WIO_WS, `ECT_RST_WMEM_DLY, `ECT_RST_WMEM_WS, `ECT_RST_ZW_MIN,
          `ECT_RST_LRD_WS, `ECT_RST_LWR_WS, `ECT_RST_LIO_DLY}};

  ect_reg_state_t cur_ff;
  ect_reg_state_t nxt_reg;
  logic [3:0]     wr_idx;

  assign wr_idx = {io_wr.data[`ECT_IDX_B3], io_wr.data[`ECT_IDX_B2],
                   io_wr.data[`ECT_IDX_B1], io_wr.data[`ECT_IDX_B0]};

  always_comb begin
    nxt_reg = cur_ff;
    if (io_wr.wr && (io_wr.addr == `ECT_PTR_ADDR)) begin
      nxt_reg.ptr = wr_idx;
    end
    if (io_wr.wr && (io_wr.addr == `ECT_DATA_ADDR)) begin
      // indices 2, 11 and 13-15 fall through untouched
      unique case (cur_ff.ptr)
        `ECT_IDX_BALE_DLY: nxt_reg.tm.latch_strobe_delay     = io_wr.data[1:0];
        `ECT_IDX_BALE_WID: nxt_reg.tm.latch_strobe_width     = io_wr.data[1:0];
        `ECT_IDX_NAR_DLY:  nxt_reg.tm.narrow_cycle_cmd_delay = io_wr.data[3:0];
        `ECT_IDX_NAR_WS:   nxt_reg.tm.narrow_cycle_waits     = io_wr.data[3:0];
        `ECT_IDX_WIO_WS:   nxt_reg.tm.wide_io_waits          = io_wr.data[3:0];
        `ECT_IDX_WMEM_DLY: nxt_reg.tm.wide_mem_cmd_delay     = io_wr.data[3:0];
        `ECT_IDX_WMEM_WS:  nxt_reg.tm.wide_mem_waits         = io_wr.data[3:0];
        `ECT_IDX_ZW_MIN:   nxt_reg.tm.zero_wait_minimum      = io_wr.data[3:0];
        `ECT_IDX_LRD_WS:   nxt_reg.tm.local_read_waits       = io_wr.data[3:0];
        `ECT_IDX_LWR_WS:   nxt_reg.tm.local_write_waits      = io_wr.data[3:0];
        `ECT_IDX_LIO_DLY:  nxt_reg.tm.local_io_cmd_delay     = io_wr.data[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cur_ff <= RESET_VAL;
    end else begin
      cur_ff <= nxt_reg;
    end
  end

  assign timing = cur_ff.tm;

  a_data_load: assert property (@(posedge clk) disable iff (reset)
    (io_wr.wr && io_wr.addr == `ECT_DATA_ADDR && cur_ff.ptr == `ECT_IDX_NAR_WS)
    |=> (timing.narrow_cycle_waits == $past(io_wr.data[3:0])))
    else $error("data write did not load selected register");

  a_unused_index: assert property (@(posedge clk) disable iff (reset)
    (io_wr.wr && io_wr.addr == `ECT_DATA_ADDR &&
     (cur_ff.ptr == `ECT_IDX_SPARE_LO || cur_ff.ptr == `ECT_IDX_SPARE_HI))
    |=> $stable(timing))
    else $error("unused index write changed a setting");
endmodule
`default_nettype wire

// ---- tb/ect_bus_agent.sv ----
// expansion bus device model: ready stretch and zero-wait answer
`timescale 1ns/100ps
`default_nettype none
module ect_bus_agent (
  // clock
  input  wire logic              clk,
  // command lines from the block
  input  wire ect_pkg::ect_cmd_t bus_cmd,
  // behaviour picked by the bench
  input  wire logic [5:0]        stall_len,
  input  wire logic              zw_on,
  // answers
  output logic                   iochrdy,
  output logic                   zero_wait_request
);
  import ect_pkg::*;
  logic       busy;
  logic [5:0] cnt = 6'h00;
  logic       rdy = 1'b1;
  logic       zw  = 1'b0;

  assign busy              = (bus_cmd[3:0] != 4'hF);
  assign iochrdy           = rdy;
  assign zero_wait_request = zw;

  // ready is pulled up, so it idles high between cycles
  always @(negedge clk) begin
    if (!busy) begin
      cnt <= 6'h00;
      rdy <= 1'b1;
      zw  <= 1'b0;
    end else begin
      cnt <= cnt + 6'h01;
      rdy <= ((cnt + 6'h01) >= stall_len);
      zw  <= zw_on;
    end
  end
endmodule
`default_nettype wire

// ---- tb/ect_cycle_ctrl_tb_top.sv ----
// bench for the command timing block: registers, strobe, delays, waits
`timescale 1ns/100ps
`default_nettype none
`include "ect_defines.svh"
module ect_cycle_ctrl_tb_top;
  import ect_pkg::*;
  // ale edge to output, two sync flops and the two-cycle ale pulse included
  localparam int CMD_OFS  = 6;
  localparam int BALE_OFS = 4;
  localparam ect_timing_t DFLT = {2'h0, 2'h1, 4'h1, 4'h4, 4'h1, 4'h0, 4'h1, 4'h0, 4'h1, 4'h1, 4'h1};
  logic                   clk;
  logic                   reset;
  logic                   io_rd;
  logic                   ale;
  logic                   zw_on;
  logic                   rdy;
  logic                   zwr;
  logic                   cpu_ready;
  logic                   io_rdata_oe;
  logic [7:0]             io_rdata;
  logic [5:0]             kind;
  logic [5:0]             stall;
  logic [`ECT_ADDR_W-1:0] io_rd_addr;
  ect_io_wr_t             io_wr;
  ect_pins_t              pins;
  ect_cmd_t               bus_cmd;
  ect_timing_t            cfg;
  logic [31:0]            rng;
  int                     error_cnt;
  int                     cmp_count;
  int                     cyc;
  int                     cl;

  // kind = {is_memory, is_write, local, memcs16, iocs16, high_speed}
  assign pins = {ale, kind[5:1], zwr, rdy, kind[0]};

  ect_cycle_ctrl DUT (
    .clk(clk), .reset(reset), .io_wr(io_wr), .io_rd(io_rd), .io_rd_addr(io_rd_addr),
    .io_rdata(io_rdata), .io_rdata_oe(io_rdata_oe), .cycle_pins(pins), .bus_cmd(bus_cmd),
    .cpu_ready(cpu_ready)
  );
  ect_bus_agent agent (
    .clk(clk), .bus_cmd(bus_cmd), .stall_len(stall), .zw_on(zw_on), .iochrdy(rdy),
    .zero_wait_request(zwr)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("errors=%0d compares=%0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic check_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    cmp_count++;
    if ($isunknown(got) || got < lo || got > hi) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%0h exp=%0h..%0h", $time, got, lo, hi);
    end
  endtask

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  task automatic next_rnd();
    rng = xorshift(rng);
  endtask

  task automatic io_write(input logic [9:0] a, input logic [7:0] d);
    @(negedge clk);
    io_wr = {1'b1, a, d};
    @(negedge clk);
    io_wr.wr = 1'b0;
  endtask

  // junk in the pointer's unused bits and the data's upper bits must be ignored
  task automatic set_reg(input logic [3:0] idx, input logic [3:0] v, input logic two);
    next_rnd();
    io_write(`ECT_PTR_ADDR, {idx[3:2], rng[1:0], idx[1:0], rng[3:2]});
    io_write(`ECT_DATA_ADDR, {rng[7:4], two ? rng[9:8] : v[3:2], v[1:0]});
  endtask

  task automatic program_all();
    set_reg(4'h0, {2'h0, cfg.latch_strobe_delay}, 1'b1);
    set_reg(4'h1, {2'h0, cfg.latch_strobe_width}, 1'b1);
    set_reg(4'h3, cfg.narrow_cycle_cmd_delay, 1'b0);
    set_reg(4'h4, cfg.narrow_cycle_waits, 1'b0);
    set_reg(4'h5, cfg.wide_io_waits, 1'b0);
    set_reg(4'h6, cfg.wide_mem_cmd_delay, 1'b0);
    set_reg(4'h7, cfg.wide_mem_waits, 1'b0);
    set_reg(4'h8, cfg.zero_wait_minimum, 1'b0);
    set_reg(4'h9, cfg.local_read_waits, 1'b0);
    set_reg(4'hA, cfg.local_write_waits, 1'b0);
    set_reg(4'hC, cfg.local_io_cmd_delay, 1'b0);
  endtask

  // returns {command delay, wait states}
  function automatic logic [8:0] exp_sel(input ect_timing_t c, input logic [5:0] k);
    logic [3:0] d;
    logic [3:0] w;
    d = c.narrow_cycle_cmd_delay;
    w = c.narrow_cycle_waits;
    if (k[3]) begin
      d = k[5] ? 4'h0 : c.local_io_cmd_delay;
      w = k[4] ? c.local_write_waits : c.local_read_waits;
    end else if (k[5] && k[2]) begin
      d = c.wide_mem_cmd_delay;
      w = c.wide_mem_waits;
    end else if (!k[5] && k[1]) begin
      w = c.wide_io_waits;
    end
    return {d, {1'b0, w} + {4'h0, k[0]}};
  endfunction

  task automatic run_cycle(input logic exact, output int len);
    int         i;
    int         b0;
    int         bw;
    int         c0;
    int         r0;
    int         rn;
    logic [8:0] e;
    e = exp_sel(cfg, kind);
    b0 = 0;
    bw = 0;
    c0 = 0;
    r0 = 0;
    rn = 0;
    len = 0;
    @(negedge clk);
    ale = 1'b1;
    for (i = 1; i < 120 && !(rn > 0 && i > r0 + 2); i++) begin
      @(negedge clk);
      if (i == 2) ale = 1'b0;
      if (bus_cmd.bale === 1'b1) begin
        if (b0 == 0) b0 = i;
        bw++;
      end
      if (bus_cmd[3:0] !== 4'hF) begin
        if (c0 == 0) check_eq({28'h0, bus_cmd[3:0]}, {28'h0, ~(4'b1000 >> {~kind[5], kind[4]})});
        if (c0 == 0) c0 = i;
        len++;
      end
      if (cpu_ready === 1'b1) begin
        if (rn == 0) r0 = i;
        rn++;
      end
    end
    check_eq(b0, BALE_OFS + cfg.latch_strobe_delay);
    check_eq(bw, cfg.latch_strobe_width);
    check_eq(c0, CMD_OFS + e[8:5]);
    if (exact) check_eq(len, 1 + 2 * e[4:0]);
    check_eq(r0, c0 + len);
    check_eq(rn, 1);
  endtask

  initial begin
    reset = 1'b1;
    io_wr = '0;
    io_rd = 1'b0;
    io_rd_addr = '0;
    ale = 1'b0;
    kind = '0;
    zw_on = 1'b0;
    stall = '0;
    rng = 32'd35;
    cfg = DFLT;
    repeat (2) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    repeat (2) @(negedge clk);
    run_cycle(1'b1, cl);
    io_rd = 1'b1;
    for (int a = 0; a < 2; a++) begin
      io_rd_addr = `ECT_PTR_ADDR + 10'(a);
      @(negedge clk);
      check_eq({23'h0, io_rdata_oe, io_rdata}, 32'h0);
    end
    io_rd = 1'b0;
    set_reg(4'h2, 4'hF, 1'b0);
    set_reg(4'hB, 4'hF, 1'b0);
    run_cycle(1'b1, cl);
    // two extremes of every count, strobe width 1 at the low end, then random settings and cycle kinds
    for (int n = 0; n < 18; n++) begin
      next_rnd();
      cfg[39:8] = rng;
      next_rnd();
      cfg[7:0] = rng[7:0];
      if (n < 2) cfg = n ? '1 : '0;
      if (cfg.latch_strobe_width == 2'h0) cfg.latch_strobe_width = 2'h1;
      program_all();
      next_rnd();
      kind = n ? rng[5:0] : 6'b000100;
      run_cycle(1'b1, cl);
    end
    cfg = DFLT;
    program_all();
    kind = 6'b000100;
    stall = 6'd12;
    run_cycle(1'b0, cl);
    check_rng(cl, 12, 18);
    stall = '0;
    cfg.narrow_cycle_waits = 4'h8;
    cfg.zero_wait_minimum = 4'h2;
    program_all();
    kind = '0;
    zw_on = 1'b1;
    run_cycle(1'b0, cl);
    check_rng(cl, 4, 9);
    zw_on = 1'b0;
    // reset in mid-run must bring every default back
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    cfg = DFLT;
    repeat (2) @(negedge clk);
    run_cycle(1'b1, cl);
    tally_and_finish();
  end
endmodule
`default_nettype wire
